//--- ltmc_pkg.sv
package ltmc_pkg;
  // =====================================================================
  // operating states, one-hot
  typedef enum logic [3:0] {
    LTMC_UNPOWERED = 4'h1,
    LTMC_STANDBY = 4'h2,
    LTMC_NORMAL = 4'h4,
    LTMC_SLEEP = 4'h8
  } ltmc_state_t;

  // =====================================================================
  // timing
  localparam int CLK_HZ = 25000000;
  localparam int T_ENABLE_US = 10;
  localparam int T_DISABLE_US = 10;
  localparam int T_WAKE_US = 30;
  localparam int T_LIN_WAKE_US = 50;
  localparam int T_TXD_TIMEOUT_US = 10000;
  localparam int CYC_ENABLE = (T_ENABLE_US * (CLK_HZ / 1000000) < 1) ? 1 :
    T_ENABLE_US * (CLK_HZ / 1000000);
  localparam int CYC_DISABLE = (T_DISABLE_US * (CLK_HZ / 1000000) < 1) ? 1 :
    T_DISABLE_US * (CLK_HZ / 1000000);
  localparam int CYC_WAKE = (T_WAKE_US * (CLK_HZ / 1000000) < 1) ? 1 :
    T_WAKE_US * (CLK_HZ / 1000000);
  localparam int CYC_LIN_WAKE = (T_LIN_WAKE_US * (CLK_HZ / 1000000) < 1) ? 1 :
    T_LIN_WAKE_US * (CLK_HZ / 1000000);
  localparam int CYC_TXD_TIMEOUT = T_TXD_TIMEOUT_US * (CLK_HZ / 1000000);
  localparam int FILT_W = 20;

  // =====================================================================
  // reset values
  localparam logic RST_PD_STRONG = 1'b0;
  localparam logic RST_RXD_LOW = 1'b0;
endpackage : ltmc_pkg

//--- ltmc_sync.sv
`timescale 1ns/1ps
`default_nettype none
// =====================================================================
// two-flop synchroniser, one per input bit
module ltmc_sync #(
  parameter int WIDTH = 4
) (
  input wire logic clk_sys, // system clock
  input wire logic reset, // sync reset, active high
  input wire logic [WIDTH-1:0] d_in, // raw inputs
  output logic [WIDTH-1:0] d_out // synchronised inputs
);
  logic [WIDTH-1:0] meta_reg;

  // first stage feeds only the second stage
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      meta_reg <= '0;
      d_out <= '0;
    end else begin
      meta_reg <= d_in;
      d_out <= meta_reg;
    end
  end
endmodule : ltmc_sync
`default_nettype wire

//--- ltmc_filter.sv
`timescale 1ns/1ps
`default_nettype none
// =====================================================================
// counts cycles that a level has held; done once count is exceeded
module ltmc_filter #(
  parameter int W = 20
) (
  input wire logic clk_sys, // system clock
  input wire logic reset, // sync reset, active high
  input wire logic hold, // level being timed
  input wire logic [W-1:0] limit, // cycles to exceed
  output logic done // level held longer than limit
);
  logic [W-1:0] cnt_reg;

  // saturating counter so done stays up while the level holds
  always_ff @(posedge clk_sys) begin
    if (reset || !hold) begin
      cnt_reg <= '0;
    end else if (cnt_reg <= limit) begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end

  assign done = hold && (cnt_reg > limit);
endmodule : ltmc_filter
`default_nettype wire

//--- ltmc_mode_ctrl.sv
// Operation
// - receive output low while bus dominant, released while recessive.
// - mode-select high requests normal; pulled low when undriven.
// - falling edge on local wake input triggers local wake; pulled high.
// - transmit input low means dominant, high recessive; pulled low.
// - transmit pull-down switches weak or strong to flag wake source.
// - regulator switch output connects battery to enable a regulator.
// - over-temperature disables the transmitter.
// - state chosen only from supply, mode-select, wake input, bus activity.
// - below power-up level, transmitter off, bus and regulator switch float.
// - unpowered state: weak transmit pull-down, receive output floating.
// - supply below power-up level forces unpowered from any state.
// - standby keeps transceiver off and drives regulator switch high.
// - standby connects the internal 30 kilohm bus pull-up.
// - standby after power-up: receive output floating, pull-down weak.
// - standby after wake-up from sleep pulls receive output low.
// - bus wake keeps pull-down weak; local wake makes it strong.
// - in standby, pin configuration ignores further wake activity.
// - bus signalling up to 20 kbit/s with reduced slew.
// - normal entered after mode-select high longer than enable filter.
// - sleep entered from normal after mode-select low past disable filter.
// - local wake needs fall then low for the wake filter time.
// - bus wake needs dominant past bus wake filter then rising edge.
`timescale 1ns/1ps
`default_nettype none
module ltmc_mode_ctrl #(
  parameter int CYC_TXD_TIMEOUT = ltmc_pkg::CYC_TXD_TIMEOUT
) (
  input wire logic clk_sys, // internal oscillator clock, 25 MHz
  input wire logic reset, // sync reset, active high
  input wire logic supply_ok, // supply above power-up level
  input wire logic supply_mon_ok, // supply above transmit monitor level
  input wire logic overtemp_cutoff, // junction over trigger level
  input wire logic mode_sel, // mode-select input, high = normal
  input wire logic txd_in, // transmit input, low = dominant
  input wire logic wake_in, // local wake input, falling edge active
  input wire logic lin_in, // bus level, low = dominant
  output logic lin_drive_dom, // drive bus dominant
  output logic lin_oe_n, // bus driver enable, low while driving
  output logic slew_limit, // reduced slew slope enable
  output logic bus_pullup_strong, // 30 kilohm pull-up connected
  output logic bus_pullup_weak, // weak current pull-up connected
  output logic rxd_out, // receive output data, always low
  output logic rxd_oe_n, // receive open-drain enable, low pulls low
  output logic txd_pd_strong, // transmit input pull-down strong
  output logic txd_pd_weak, // transmit input pull-down weak
  output logic regulator_switch_output, // switch high
  output logic regulator_switch_oe_n, // switch enable, low while driving
  output logic [3:0] state_out // current state, one-hot
);
  // =====================================================================
  // input synchronisation
  logic [3:0] sync_q;
  logic mode_s, txd_s, wake_s, lin_s, wake_d_reg, lin_d_reg;

  // idle-high pins pass inverted so the zero reset of the synchroniser reads as
  // idle, which keeps a false falling edge out of the wake and bus detectors
  ltmc_sync #(.WIDTH(4)) u_sync (
    .clk_sys(clk_sys),
    .reset(reset),
    .d_in({mode_sel, ~txd_in, ~wake_in, ~lin_in}),
    .d_out(sync_q)
  );
  assign mode_s = sync_q[3];
  assign txd_s = ~sync_q[2];
  assign wake_s = ~sync_q[1];
  assign lin_s = ~sync_q[0];

  // edge history of synchronised inputs
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      wake_d_reg <= 1'b1;
      lin_d_reg <= 1'b1;
    end else begin
      wake_d_reg <= wake_s;
      lin_d_reg <= lin_s;
    end
  end

  // =====================================================================
  // state and filters
  ltmc_pkg::ltmc_state_t state_reg, state_next;
  logic en_done, dis_done, wake_low_done, lin_dom_done;
  logic wake_armed_reg, lin_armed_reg, local_wake, bus_wake, wake_window;

  ltmc_filter #(.W(ltmc_pkg::FILT_W)) u_en_filt (
    .clk_sys(clk_sys),
    .reset(reset),
    .hold(mode_s),
    .limit(ltmc_pkg::FILT_W'(ltmc_pkg::CYC_ENABLE)),
    .done(en_done)
  );
  ltmc_filter #(.W(ltmc_pkg::FILT_W)) u_dis_filt (
    .clk_sys(clk_sys),
    .reset(reset),
    .hold(!mode_s && state_reg == ltmc_pkg::LTMC_NORMAL),
    .limit(ltmc_pkg::FILT_W'(ltmc_pkg::CYC_DISABLE)),
    .done(dis_done)
  );
  ltmc_filter #(.W(ltmc_pkg::FILT_W)) u_wake_filt (
    .clk_sys(clk_sys),
    .reset(reset),
    .hold(wake_armed_reg && !wake_s),
    .limit(ltmc_pkg::FILT_W'(ltmc_pkg::CYC_WAKE)),
    .done(wake_low_done)
  );
  ltmc_filter #(.W(ltmc_pkg::FILT_W)) u_lin_filt (
    .clk_sys(clk_sys),
    .reset(reset),
    .hold(!lin_s),
    .limit(ltmc_pkg::FILT_W'(ltmc_pkg::CYC_LIN_WAKE)),
    .done(lin_dom_done)
  );

  // wake detection is live in sleep and while the disable filter runs
  assign wake_window = (state_reg == ltmc_pkg::LTMC_SLEEP) ||
    (state_reg == ltmc_pkg::LTMC_NORMAL && !mode_s);

  // arm local wake on a falling edge; a long-low level alone never wakes
  always_ff @(posedge clk_sys) begin
    if (reset || wake_s) begin
      wake_armed_reg <= 1'b0;
    end else if (wake_d_reg && !wake_s) begin
      wake_armed_reg <= 1'b1;
    end
  end

  // remember that the bus stayed dominant long enough
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      lin_armed_reg <= 1'b0;
    end else if (lin_dom_done) begin
      lin_armed_reg <= 1'b1;
    end else if (lin_s) begin
      lin_armed_reg <= 1'b0;
    end
  end

  assign local_wake = wake_window && wake_low_done;
  assign bus_wake = wake_window && lin_armed_reg && lin_s && !lin_d_reg;

  // next-state logic
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ltmc_pkg::LTMC_UNPOWERED: begin
        if (supply_ok) begin
          state_next = ltmc_pkg::LTMC_STANDBY;
        end
      end
      ltmc_pkg::LTMC_STANDBY: begin
        if (en_done) begin
          state_next = ltmc_pkg::LTMC_NORMAL;
        end
      end
      ltmc_pkg::LTMC_NORMAL: begin
        if (local_wake || bus_wake) begin
          state_next = ltmc_pkg::LTMC_STANDBY;
        end else if (dis_done) begin
          state_next = ltmc_pkg::LTMC_SLEEP;
        end
      end
      ltmc_pkg::LTMC_SLEEP: begin
        if (en_done) begin
          state_next = ltmc_pkg::LTMC_NORMAL;
        end else if (local_wake || bus_wake) begin
          state_next = ltmc_pkg::LTMC_STANDBY;
        end
      end
      default: begin
        state_next = ltmc_pkg::LTMC_UNPOWERED;
      end
    endcase
    if (!supply_ok) begin
      state_next = ltmc_pkg::LTMC_UNPOWERED;
    end
  end

  // state register driven only by supply, mode, wake and bus
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state_reg <= ltmc_pkg::LTMC_UNPOWERED;
    end else begin
      state_reg <= state_next;
    end
  end

  // =====================================================================
  // wake source flags for standby pin configuration
  logic rxd_flag_reg, pd_strong_reg;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rxd_flag_reg <= ltmc_pkg::RST_RXD_LOW;
      pd_strong_reg <= ltmc_pkg::RST_PD_STRONG;
    end else if (state_reg == ltmc_pkg::LTMC_UNPOWERED) begin
      rxd_flag_reg <= 1'b0;
      pd_strong_reg <= 1'b0;
    end else if (state_reg != ltmc_pkg::LTMC_STANDBY &&
                 state_next == ltmc_pkg::LTMC_STANDBY) begin
      rxd_flag_reg <= 1'b1;
      pd_strong_reg <= local_wake;
    end else if (state_reg == ltmc_pkg::LTMC_STANDBY && mode_s) begin
      // cleared as soon as mode-select rises, ahead of the enable filter
      rxd_flag_reg <= 1'b0;
      pd_strong_reg <= 1'b0;
    end
    // otherwise held in standby, ignoring wake activity
  end

  // =====================================================================
  // transmitter: dominant timeout and thermal lockout
  logic [23:0] txd_low_cnt_reg;
  logic tx_lock_reg, tx_allowed;

  // timeout protects the bus from a stuck-low transmit input
  always_ff @(posedge clk_sys) begin
    if (reset || txd_s) begin
      txd_low_cnt_reg <= '0;
    end else if (txd_low_cnt_reg <= 24'(CYC_TXD_TIMEOUT)) begin
      txd_low_cnt_reg <= txd_low_cnt_reg + 24'h1;
    end
  end

  // after over-temperature, wait for a recessive transmit level to avoid oscillation
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      tx_lock_reg <= 1'b0;
    end else if (overtemp_cutoff) begin
      tx_lock_reg <= 1'b1;
    end else if (txd_s) begin
      tx_lock_reg <= 1'b0;
    end
  end

  // next state is used so the driver lets go at the very edge that leaves normal
  assign tx_allowed = (state_next == ltmc_pkg::LTMC_NORMAL) && !overtemp_cutoff &&
    !tx_lock_reg && supply_mon_ok;

  // =====================================================================
  // pin drives per state
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      lin_drive_dom <= 1'b0;
      lin_oe_n <= 1'b1;
    end else begin
      lin_drive_dom <= 1'b0;
      lin_oe_n <= !(tx_allowed && !txd_s &&
        txd_low_cnt_reg <= 24'(CYC_TXD_TIMEOUT));
    end
  end

  assign slew_limit = 1'b1;
  assign rxd_out = 1'b0;
  // open drain mirrors the bus in normal, flags a wake in standby
  assign rxd_oe_n = (state_reg == ltmc_pkg::LTMC_NORMAL) ? lin_s :
    (state_reg == ltmc_pkg::LTMC_STANDBY) ? !rxd_flag_reg : 1'b1;
  assign txd_pd_strong = (state_reg == ltmc_pkg::LTMC_STANDBY) && pd_strong_reg;
  assign txd_pd_weak = !txd_pd_strong;
  assign bus_pullup_strong = state_reg == ltmc_pkg::LTMC_STANDBY ||
    state_reg == ltmc_pkg::LTMC_NORMAL;
  assign bus_pullup_weak = state_reg == ltmc_pkg::LTMC_SLEEP;
  assign regulator_switch_output = 1'b1;
  assign regulator_switch_oe_n = !(state_reg == ltmc_pkg::LTMC_STANDBY ||
    state_reg == ltmc_pkg::LTMC_NORMAL);
  assign state_out = state_reg;

  // =====================================================================
  // run lengths kept apart from the filters, so the checks do not lean on them
  logic [ltmc_pkg::FILT_W-1:0] mode_hi_run_reg, mode_lo_run_reg;
  logic [ltmc_pkg::FILT_W-1:0] wake_lo_run_reg, lin_lo_run_reg;

  // mode-select run lengths, saturating
  always_ff @(posedge clk_sys) begin
    if (reset || !mode_s) begin
      mode_hi_run_reg <= '0;
    end else if (!(&mode_hi_run_reg)) begin
      mode_hi_run_reg <= mode_hi_run_reg + 1'b1;
    end
    if (reset || mode_s) begin
      mode_lo_run_reg <= '0;
    end else if (!(&mode_lo_run_reg)) begin
      mode_lo_run_reg <= mode_lo_run_reg + 1'b1;
    end
  end

  // low run lengths of the wake pin and the bus, saturating
  always_ff @(posedge clk_sys) begin
    if (reset || wake_s) begin
      wake_lo_run_reg <= '0;
    end else if (!(&wake_lo_run_reg)) begin
      wake_lo_run_reg <= wake_lo_run_reg + 1'b1;
    end
    if (reset || lin_s) begin
      lin_lo_run_reg <= '0;
    end else if (!(&lin_lo_run_reg)) begin
      lin_lo_run_reg <= lin_lo_run_reg + 1'b1;
    end
  end

  // =====================================================================
  // checks
  unpowered_quiet_a: assert property (@(posedge clk_sys) disable iff (reset)
    state_reg == ltmc_pkg::LTMC_UNPOWERED |-> lin_oe_n && regulator_switch_oe_n && rxd_oe_n)
    else $error("unpowered state drives a pin");
  unpowered_pd_a: assert property (@(posedge clk_sys) disable iff (reset)
    state_reg == ltmc_pkg::LTMC_UNPOWERED |-> txd_pd_weak && !txd_pd_strong)
    else $error("unpowered pull-down not weak");
  supply_drop_a: assert property (@(posedge clk_sys) disable iff (reset)
    !supply_ok |=> state_reg == ltmc_pkg::LTMC_UNPOWERED)
    else $error("supply loss did not unpower");
  standby_reg_a: assert property (@(posedge clk_sys) disable iff (reset)
    state_reg == ltmc_pkg::LTMC_STANDBY |-> !regulator_switch_oe_n && lin_oe_n)
    else $error("standby pins wrong");
  powerup_cfg_a: assert property (@(posedge clk_sys) disable iff (reset)
    $past(state_reg) == ltmc_pkg::LTMC_UNPOWERED && state_reg == ltmc_pkg::LTMC_STANDBY
    |-> rxd_oe_n && !txd_pd_strong)
    else $error("power-up standby config wrong");
  wake_flag_a: assert property (@(posedge clk_sys) disable iff (reset)
    $past(state_reg) == ltmc_pkg::LTMC_SLEEP && state_reg == ltmc_pkg::LTMC_STANDBY
    |-> !rxd_oe_n)
    else $error("wake not flagged on receive output");
  standby_hold_a: assert property (@(posedge clk_sys) disable iff (reset)
    state_reg == ltmc_pkg::LTMC_STANDBY && $past(state_reg) == ltmc_pkg::LTMC_STANDBY &&
    !$past(mode_s) |-> $stable(txd_pd_strong) && $stable(rxd_oe_n))
    else $error("standby config changed");
  overtemp_off_a: assert property (@(posedge clk_sys) disable iff (reset)
    overtemp_cutoff |=> lin_oe_n)
    else $error("transmitter on during over-temperature");
  rx_follow_a: assert property (@(posedge clk_sys) disable iff (reset)
    state_reg == ltmc_pkg::LTMC_NORMAL |-> rxd_oe_n == lin_s)
    else $error("receive output does not follow bus");
  normal_entry_a: assert property (@(posedge clk_sys) disable iff (reset)
    state_reg != ltmc_pkg::LTMC_NORMAL && state_next == ltmc_pkg::LTMC_NORMAL |->
    mode_hi_run_reg > ltmc_pkg::FILT_W'(ltmc_pkg::CYC_ENABLE))
    else $error("normal entered before enable filter");
  sleep_entry_a: assert property (@(posedge clk_sys) disable iff (reset)
    state_reg == ltmc_pkg::LTMC_NORMAL && state_next == ltmc_pkg::LTMC_SLEEP |->
    mode_lo_run_reg > ltmc_pkg::FILT_W'(ltmc_pkg::CYC_DISABLE))
    else $error("sleep entered before disable filter");
  wake_entry_a: assert property (@(posedge clk_sys) disable iff (reset)
    (state_reg == ltmc_pkg::LTMC_SLEEP || state_reg == ltmc_pkg::LTMC_NORMAL) &&
    state_next == ltmc_pkg::LTMC_STANDBY |->
    wake_lo_run_reg > ltmc_pkg::FILT_W'(ltmc_pkg::CYC_WAKE) || (lin_s && !lin_d_reg &&
    lin_lo_run_reg > ltmc_pkg::FILT_W'(ltmc_pkg::CYC_LIN_WAKE)))
    else $error("wake accepted before its filter time");
  standby_pullup_a: assert property (@(posedge clk_sys) disable iff (reset)
    state_reg == ltmc_pkg::LTMC_STANDBY |-> bus_pullup_strong && !bus_pullup_weak)
    else $error("standby bus pull-up wrong");
  sleep_pins_a: assert property (@(posedge clk_sys) disable iff (reset)
    state_reg == ltmc_pkg::LTMC_SLEEP |-> regulator_switch_oe_n && lin_oe_n && bus_pullup_weak)
    else $error("sleep pins wrong");
  local_strong_a: assert property (@(posedge clk_sys) disable iff (reset)
    $past(state_reg) == ltmc_pkg::LTMC_SLEEP && state_reg == ltmc_pkg::LTMC_STANDBY &&
    $past(!lin_s || lin_d_reg) |-> txd_pd_strong)
    else $error("local wake left pull-down weak");
  bus_weak_a: assert property (@(posedge clk_sys) disable iff (reset)
    $past(state_reg) == ltmc_pkg::LTMC_SLEEP && state_reg == ltmc_pkg::LTMC_STANDBY &&
    $past(wake_s) |-> !txd_pd_strong)
    else $error("bus wake made pull-down strong");
endmodule : ltmc_mode_ctrl
`default_nettype wire

//--- ltmc_partner.sv
`timescale 1ns/1ps
`default_nettype none
// =====================================================================
// controller and bus side: resolves pulls and the wired bus level
module ltmc_partner (
  input wire logic mode_drv, // controller mode-select level
  input wire logic mode_en, // controller drives mode-select
  input wire logic txd_drv, // controller transmit level
  input wire logic txd_en, // controller drives transmit pin
  input wire logic wake_closed, // local switch pulls wake pin low
  input wire logic node_dom, // another node drives bus dominant
  input wire logic lin_drive_dom, // device bus data
  input wire logic lin_oe_n, // device bus enable, low driving
  input wire logic rxd_out, // device receive data
  input wire logic rxd_oe_n, // device receive enable, low driving
  output logic mode_sel, // resolved mode-select pin
  output logic txd_in, // resolved transmit pin
  output logic wake_in, // resolved wake pin
  output logic lin_in, // resolved bus level
  output logic rxd_pin // receive pin seen by controller
);
  // undriven pins fall to their device-side pulls
  assign mode_sel = mode_en ? mode_drv : 1'b0;
  assign txd_in = txd_en ? txd_drv : 1'b0;
  assign wake_in = wake_closed ? 1'b0 : 1'b1;
  // wired-and bus: any dominant driver wins over the pull-up
  assign lin_in = node_dom ? 1'b0 : (lin_oe_n ? 1'b1 : lin_drive_dom);
  // controller pull-up on the open-drain receive pin
  assign rxd_pin = rxd_oe_n ? 1'b1 : rxd_out;
endmodule : ltmc_partner
`default_nettype wire

//--- ltmc_mode_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
module ltmc_mode_ctrl_tb;
  localparam logic [3:0] S_UNP = 4'h1;
  localparam logic [3:0] S_STB = 4'h2;
  localparam logic [3:0] S_NRM = 4'h4;
  localparam logic [3:0] S_SLP = 4'h8;
  logic clk_sys, reset, supply_ok, overtemp_cutoff;
  logic mode_drv, mode_en, txd_drv, txd_en, wake_closed, node_dom;
  logic mode_sel, txd_in, wake_in, lin_in, rxd_pin;
  logic lin_drive_dom, lin_oe_n, slew_limit, bus_pullup_strong, bus_pullup_weak;
  logic rxd_out, rxd_oe_n, txd_pd_strong, txd_pd_weak;
  logic regulator_switch_output, regulator_switch_oe_n;
  logic [3:0] state_out;
  int mismatches, checked;

  // =====================================================================
  // design and far side
  ltmc_mode_ctrl #(.CYC_TXD_TIMEOUT(100)) dut_u (.clk_sys(clk_sys), .reset(reset),
    .supply_ok(supply_ok), .supply_mon_ok(1'b1), .overtemp_cutoff(overtemp_cutoff),
    .mode_sel(mode_sel), .txd_in(txd_in), .wake_in(wake_in), .lin_in(lin_in),
    .lin_drive_dom(lin_drive_dom), .lin_oe_n(lin_oe_n), .slew_limit(slew_limit),
    .bus_pullup_strong(bus_pullup_strong), .bus_pullup_weak(bus_pullup_weak),
    .rxd_out(rxd_out), .rxd_oe_n(rxd_oe_n), .txd_pd_strong(txd_pd_strong),
    .txd_pd_weak(txd_pd_weak), .regulator_switch_output(regulator_switch_output),
    .regulator_switch_oe_n(regulator_switch_oe_n), .state_out(state_out));
  ltmc_partner far_u (.mode_drv(mode_drv), .mode_en(mode_en), .txd_drv(txd_drv),
    .txd_en(txd_en), .wake_closed(wake_closed), .node_dom(node_dom),
    .lin_drive_dom(lin_drive_dom), .lin_oe_n(lin_oe_n), .rxd_out(rxd_out),
    .rxd_oe_n(rxd_oe_n), .mode_sel(mode_sel), .txd_in(txd_in), .wake_in(wake_in),
    .lin_in(lin_in), .rxd_pin(rxd_pin));

  // =====================================================================
  // clock and watchdog
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  // the whole run needs about 6150 cycles; 20000 leaves a wide margin
  initial begin
    #(40 * 20000);
    mismatches++;
    end_of_test();
  end

  // =====================================================================
  // helpers
  task cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : cyc
  task chk(input logic got, input logic exp, input string msg);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask : chk
  task chk_st(input logic [3:0] exp);
    checked++;
    if (state_out !== exp) begin
      mismatches++;
      $display("[FAIL] %0t state %h expected %h", $time, state_out, exp);
    end
  endtask : chk_st
  // bounded wait on the state, then judge it
  task wait_st(input logic [3:0] exp, input int lim);
    int i;
    i = 0;
    while (state_out !== exp && i < lim) begin
      cyc(1);
      i++;
    end
    chk_st(exp);
  endtask : wait_st
  // mode-select held long enough for the enable or disable filter (250)
  task set_mode(input logic lvl, input logic [3:0] to, input logic [3:0] from);
    mode_drv = lvl;
    cyc(200);
    chk_st(from);
    wait_st(to, 80);
  endtask : set_mode

  // =====================================================================
  // scenarios
  task t_power_up;
    chk_st(S_UNP);
    chk(regulator_switch_oe_n, 1'b1, "switch floats unpowered");
    chk(lin_oe_n, 1'b1, "bus floats unpowered");
    chk(txd_pd_weak, 1'b1, "weak pull-down unpowered");
    chk(rxd_pin, 1'b1, "receive floats unpowered");
    supply_ok = 1'b1;
    wait_st(S_STB, 5);
    chk(regulator_switch_oe_n | ~regulator_switch_output, 1'b0, "switch on");
    chk(lin_oe_n, 1'b1, "transmitter off in standby");
    chk(bus_pullup_strong, 1'b1, "pull-up in standby");
    chk(rxd_pin, 1'b1, "receive floats after power-up");
    chk(txd_pd_strong, 1'b0, "pull-down weak after power-up");
  endtask : t_power_up

  task t_normal_traffic;
    mode_en = 1'b1;
    set_mode(1'b1, S_NRM, S_STB);
    chk(slew_limit, 1'b1, "reduced slew");
    chk(rxd_pin, 1'b1, "recessive bus");
    txd_drv = 1'b0;
    cyc(3);
    chk(lin_oe_n, 1'b0, "dominant sent");
    cyc(3);
    chk(rxd_pin, 1'b0, "own dominant received");
    overtemp_cutoff = 1'b1;
    cyc(3);
    chk(lin_oe_n, 1'b1, "over-temperature release");
    overtemp_cutoff = 1'b0;
    cyc(4);
    chk(lin_oe_n, 1'b1, "stays off until transmit high");
    txd_drv = 1'b1;
    cyc(4);
    chk(rxd_pin, 1'b1, "recessive again");
    node_dom = 1'b1;
    cyc(4);
    chk(rxd_pin, 1'b0, "other node dominant");
    node_dom = 1'b0;
    txd_drv = 1'b0;
    cyc(4);
    chk(lin_oe_n, 1'b0, "transmit enabled again");
    txd_drv = 1'b1;
    cyc(2);
  endtask : t_normal_traffic

  task t_sleep;
    set_mode(1'b0, S_SLP, S_NRM);
    chk(regulator_switch_oe_n, 1'b1, "switch off in sleep");
    chk(bus_pullup_weak & ~bus_pullup_strong, 1'b1, "weak bus pull-up");
    chk(lin_oe_n, 1'b1, "transmitter off in sleep");
  endtask : t_sleep

  task t_local_wake;
    wake_closed = 1'b1;
    cyc(300);
    wake_closed = 1'b0;
    cyc(20);
    chk_st(S_SLP);
    wake_closed = 1'b1;
    cyc(700);
    chk_st(S_SLP);
    wait_st(S_STB, 100);
    wake_closed = 1'b0;
    chk(rxd_pin, 1'b0, "wake flagged on receive");
    chk(txd_pd_strong & ~txd_pd_weak, 1'b1, "strong after local wake");
    node_dom = 1'b1;
    cyc(1300);
    node_dom = 1'b0;
    cyc(20);
    chk_st(S_STB);
    chk(rxd_pin, 1'b0, "receive flag held");
    chk(txd_pd_strong, 1'b1, "pull-down held strong");
    set_mode(1'b1, S_NRM, S_STB);
    chk(rxd_pin, 1'b1, "receive released in normal");
    set_mode(1'b0, S_SLP, S_NRM);
  endtask : t_local_wake

  task t_bus_wake;
    node_dom = 1'b1;
    cyc(1000);
    node_dom = 1'b0;
    cyc(20);
    chk_st(S_SLP);
    node_dom = 1'b1;
    cyc(1300);
    chk_st(S_SLP);
    node_dom = 1'b0;
    wait_st(S_STB, 10);
    chk(rxd_pin, 1'b0, "wake flagged on receive");
    chk(txd_pd_weak & ~txd_pd_strong, 1'b1, "weak after bus wake");
  endtask : t_bus_wake

  task t_supply_drop;
    set_mode(1'b1, S_NRM, S_STB);
    txd_drv = 1'b0;
    cyc(3);
    chk(lin_oe_n, 1'b0, "driving before drop");
    cyc(110);
    chk(lin_oe_n, 1'b1, "stuck dominant released");
    txd_drv = 1'b1;
    cyc(3);
    txd_drv = 1'b0;
    cyc(3);
    chk(lin_oe_n, 1'b0, "driving again after release");
    supply_ok = 1'b0;
    wait_st(S_UNP, 3);
    chk(lin_oe_n, 1'b1, "bus floats after drop");
    chk(regulator_switch_oe_n, 1'b1, "switch floats after drop");
    chk(txd_pd_weak & rxd_oe_n, 1'b1, "unpowered pins");
  endtask : t_supply_drop

  // =====================================================================
  // verdict
  task end_of_test;
    $display("mismatches %0d checked %0d", mismatches, checked);
    if (mismatches == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_of_test

  initial begin
    mismatches = 0;
    checked = 0;
    reset = 1'b1;
    supply_ok = 1'b0;
    overtemp_cutoff = 1'b0;
    mode_drv = 1'b0;
    mode_en = 1'b0;
    txd_drv = 1'b1;
    txd_en = 1'b1;
    wake_closed = 1'b0;
    node_dom = 1'b0;
    cyc(6);
    reset = 1'b0;
    cyc(2);
    t_power_up();
    t_normal_traffic();
    t_sleep();
    t_local_wake();
    t_bus_wake();
    t_supply_drop();
    end_of_test();
  end
endmodule : ltmc_mode_ctrl_tb
`default_nettype wire
